// File: src/tsm_monitor.sv
// Transformer load-state monitor: load classification, cumulative
// overload timers, nameplate data in eight groups, APB register slave.
// Assumes currents in 0.1 A steps from scaling logic on the same clock.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps

// Overview of operation
// - No-load only after >10 ms below 0.2 In
// - From no-load above 1.3 In: both inrush
// - Normal load between no-load and nominal
// - Overloading between nominal and heavy threshold
// - Compare currents against derived nominal currents
// - Accumulate overload and high-overcurrent time
// - Status changes raise events; outputs visible
// - Forcing overrides outputs while globally enabled, except in mode Off
// - Mode setting, default On, gated globally
// - Read-only behaviour shows mode in effect
// - Optional group switch changes nameplate one clock later
// - Rated power feeds both nominal currents
// - HV voltage sets HV nominal current
// - LV voltage sets LV nominal current
// - Impedance percent gives short-circuit current
// - Frequency gives short-circuit inductance
// - Shared-setting writes update this copy
module tsm_monitor
    import tsm_pkg::*;
#(
    parameter int unsigned NOLOAD_CYCLES = NOLOAD_CYC,
    parameter int unsigned MS_CYCLES     = MS_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [19:0] meas_cur_hv,
    input  wire logic [19:0] meas_cur_lv,
    input  wire logic        allow_node_operating_mode,
    input  wire logic        stage_force_en,
    input  wire logic [2:0]  settings_group_select,
    input  wire logic        shw_valid,
    input  wire tsm_shw_t    shw_req,
    output logic             shw_ready,
    output tsm_stat_t        stat_out,
    output logic             evt_valid,
    output tsm_stat_t        evt_stat,
    output logic             evt_test
);
    // Range check of a nameplate word
    function automatic logic np_ok(input logic [2:0] f, input logic [15:0] d);
        unique case (f)
            NP_P, NP_UHV, NP_ULV: np_ok = d >= MIN_PU && d <= MAX_PU;
            NP_ZK:                np_ok = d >= MIN_PU && d <= MAX_ZK;
            NP_F:                 np_ok = d >= MIN_F && d <= MAX_F;
            default:              np_ok = 1'b0;
        endcase
    endfunction : np_ok

    // Load band of one winding: 0 light, 1 normal, 2 over, 3 heavy
    function automatic logic [1:0] band(input logic [19:0] cur,
                                        input logic [31:0] inom);
        logic [39:0] c;
        logic [39:0] n;
        c = 40'(cur) * 40'(TH_NOM_X10);
        n = 40'(inom);
        if (c > n * 40'(TH_HEAVY_X10))     band = 2'h3;
        else if (c > n * 40'(TH_NOM_X10))  band = 2'h2;
        else if (c < n * 40'(TH_NOLOAD_X10)) band = 2'h0;
        else                               band = 2'h1;
    endfunction : band

    function automatic tsm_stat_t frc2stat(input tsm_force_t f);
        tsm_stat_t s;
        s = '0;
        s.noload    = f == TSM_FRC_NOLOAD;
        s.inrush_hv = f == TSM_FRC_INR_HV;
        s.inrush_lv = f == TSM_FRC_INR_LV;
        s.normal    = f == TSM_FRC_NORMAL;
        s.overload  = f == TSM_FRC_OVER;
        s.high_ol   = f == TSM_FRC_HIGH;
        return s;
    endfunction : frc2stat

    logic [15:0]  np_mem_ff [NUM_GROUPS][NUM_NP];
    logic [31:0]  ctrl_ff;
    tsm_mode_t    mode_ff;
    tsm_mode_t    behav_ff;
    tsm_force_t   force_ff;
    tsm_state_t   state_ff;
    tsm_state_t   nxt_state;
    tsm_stat_t    stat_ff;
    tsm_stat_t    nxt_stat;
    logic [2:0]   grp_ff;
    logic [31:0]  nl_cnt_ff;
    logic [31:0]  ms_cnt_ff;
    logic [31:0]  ol_time_ff;
    logic [31:0]  ho_time_ff;
    logic [31:0]  prdata_ff;
    logic         pready_ff;
    logic         pslverr_ff;
    logic         shw_ready_ff;
    logic         evt_valid_ff;
    tsm_stat_t    evt_stat_ff;
    logic         evt_test_ff;
    logic [DIV_W-1:0] num [NUM_DIV];
    logic [DIV_W-1:0] den [NUM_DIV];
    logic [DIV_W-1:0] quo [NUM_DIV];
    logic [NUM_DIV-1:0] dvld;

    // APB decode; answer one cycle into the access phase
    wire        acc      = psel & penable & ~pready_ff;
    wire        commit   = psel & penable & pready_ff;
    wire [7:0]  np_off   = paddr - OFF_NP_BASE;
    wire [2:0]  np_fld   = np_off[4:2];
    wire        np_hit   = paddr >= OFF_NP_BASE && paddr < OFF_IN_HV;
    wire        reg_hit  = paddr[1:0] == 2'h0 && paddr <= OFF_LK;
    wire        bad      = ~reg_hit | (pwrite & np_hit & ~np_ok(np_fld,
                                                        pwdata[15:0]));
    wire        wr       = commit & pwrite & ~bad;
    wire [2:0]  edit_grp = ctrl_ff[CTRL_EDIT_LSB +: 3];
    wire        shw_take = shw_valid & shw_ready_ff
                           & np_ok(shw_req.field, shw_req.data);

    // Active group follows the selector only when group control is on
    wire [2:0]  nxt_grp  = ctrl_ff[CTRL_SG_BIT] ? settings_group_select
                                                : 3'h0;
    wire [15:0] p   = np_mem_ff[grp_ff][NP_P];
    wire [15:0] uhv = np_mem_ff[grp_ff][NP_UHV];
    wire [15:0] ulv = np_mem_ff[grp_ff][NP_ULV];
    wire [15:0] zk  = np_mem_ff[grp_ff][NP_ZK];
    wire [15:0] fn  = np_mem_ff[grp_ff][NP_F];
    wire [31:0] in_hv = quo[0][31:0];
    wire [31:0] in_lv = quo[1][31:0];

    // Derived quantities: In = P / (sqrt3 U), Isc = In / zk, Lk from f
    assign num[0] = DIV_W'(p) * DIV_W'(IN_SCALE);
    assign den[0] = DIV_W'(uhv) * DIV_W'(SQRT3_Q10);
    assign num[1] = DIV_W'(p) * DIV_W'(IN_SCALE);
    assign den[1] = DIV_W'(ulv) * DIV_W'(SQRT3_Q10);
    assign num[2] = DIV_W'(in_hv) * DIV_W'(ISC_SCALE);
    assign den[2] = DIV_W'(zk);
    assign num[3] = DIV_W'(zk) * DIV_W'(uhv) * DIV_W'(uhv) * DIV_W'(LK_SCALE);
    assign den[3] = DIV_W'(p) * DIV_W'(fn) * DIV_W'(TWO_PI_Q10);

    for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
        tsm_div #(.W(DIV_W)) u_div (
            .clk_sys (clk_sys),
            .sys_rst (sys_rst),
            .num     (num[i]),
            .den     (den[i]),
            .quo     (quo[i]),
            .ready   (dvld[i])
        );
    end

    // Worst winding decides; light only when both windings are light
    wire [1:0] b_hv  = band(meas_cur_hv, in_hv);
    wire [1:0] b_lv  = band(meas_cur_lv, in_lv);
    wire [1:0] lvl   = b_hv > b_lv ? b_hv : b_lv;
    wire       nl_ok = nl_cnt_ff >= NOLOAD_CYCLES;
    wire       ms_tick = ms_cnt_ff == MS_CYCLES - 1;
    wire       run   = behav_ff == TSM_MODE_ON || behav_ff == TSM_MODE_TEST;
    wire       frc   = stage_force_en && force_ff != TSM_FRC_NONE;

    // Load state machine; waits until nominal currents are known
    always_comb begin
        nxt_state = state_ff;
        if (&dvld) begin
            unique case (lvl)
                2'h0: nxt_state = nl_ok ? TSM_ST_NOLOAD
                                : (state_ff == TSM_ST_NOLOAD ? TSM_ST_NOLOAD
                                                             : TSM_ST_NORMAL);
                2'h1: nxt_state = TSM_ST_NORMAL;
                2'h2: nxt_state = TSM_ST_OVER;
                2'h3: nxt_state = (state_ff == TSM_ST_NOLOAD
                                   || state_ff == TSM_ST_INRUSH)
                                  ? TSM_ST_INRUSH : TSM_ST_HIGH;
            endcase
        end
    end

    // Output selection: off clears, forcing wins, blocked clears
    always_comb begin
        nxt_stat = '0;
        if (behav_ff == TSM_MODE_OFF) begin
            nxt_stat = '0;
        end else if (frc) begin
            nxt_stat = frc2stat(force_ff);
        end else if (run) begin
            nxt_stat.noload    = state_ff == TSM_ST_NOLOAD;
            nxt_stat.inrush_hv = state_ff == TSM_ST_INRUSH;
            nxt_stat.inrush_lv = state_ff == TSM_ST_INRUSH;
            nxt_stat.normal    = state_ff == TSM_ST_NORMAL;
            nxt_stat.overload  = state_ff == TSM_ST_OVER;
            nxt_stat.high_ol   = state_ff == TSM_ST_HIGH;
        end
    end

    // Register read selection
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        if (np_hit) begin
            rd_mux = {16'h0000, np_mem_ff[edit_grp][np_fld]};
        end else begin
            unique case (paddr)
                OFF_CTRL:    rd_mux = ctrl_ff;
                OFF_MODE:    rd_mux = {29'h0, mode_ff};
                OFF_BEHAV:   rd_mux = {29'h0, behav_ff};
                OFF_FORCE:   rd_mux = {29'h0, force_ff};
                OFF_STATUS:  rd_mux = {21'h0, grp_ff, 2'h0, stat_ff};
                OFF_OL_TIME: rd_mux = ol_time_ff;
                OFF_HO_TIME: rd_mux = ho_time_ff;
                OFF_IN_HV:   rd_mux = in_hv;
                OFF_IN_LV:   rd_mux = in_lv;
                OFF_ISC:     rd_mux = quo[2][31:0];
                OFF_LK:      rd_mux = quo[3][31:0];
                default:     rd_mux = '0;
            endcase
        end
    end

    // APB handshake; shared port stalls in the cycle a write commits
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pready_ff    <= 1'b0;
            pslverr_ff   <= 1'b0;
            prdata_ff    <= '0;
            shw_ready_ff <= 1'b1;
        end else begin
            pready_ff    <= acc;
            pslverr_ff   <= acc & bad;
            prdata_ff    <= (acc & ~pwrite) ? rd_mux : '0;
            shw_ready_ff <= ~(acc & pwrite);
        end
    end

    // Settings; mode writes only while individual mode is allowed
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_ff  <= '0;
            mode_ff  <= TSM_MODE_ON;
            force_ff <= TSM_FRC_NONE;
            for (int g = 0; g < NUM_GROUPS; g++) begin
                np_mem_ff[g][NP_P]   <= RST_P;
                np_mem_ff[g][NP_UHV] <= RST_U;
                np_mem_ff[g][NP_ULV] <= RST_U;
                np_mem_ff[g][NP_ZK]  <= RST_ZK;
                np_mem_ff[g][NP_F]   <= RST_F;
            end
        end else begin
            if (wr && paddr == OFF_CTRL) ctrl_ff <= {27'h0, pwdata[4:0]};
            if (wr && paddr == OFF_MODE && allow_node_operating_mode
                && pwdata[2:0] <= TSM_MODE_OFF)
                mode_ff <= tsm_mode_t'(pwdata[2:0]);
            if (wr && paddr == OFF_FORCE && pwdata[2:0] <= TSM_FRC_HIGH)
                force_ff <= tsm_force_t'(pwdata[2:0]);
            if (wr && np_hit)
                np_mem_ff[edit_grp][np_fld] <= pwdata[15:0];
            else if (shw_take)
                np_mem_ff[shw_req.group][shw_req.field] <= shw_req.data;
        end
    end

    // Load state, no-load timing and cumulative time counters
    wire clr_ol = wr && paddr == OFF_TCLR && pwdata[TCLR_OL_BIT];
    wire clr_ho = wr && paddr == OFF_TCLR && pwdata[TCLR_HO_BIT];
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_ff   <= TSM_ST_NORMAL;
            nl_cnt_ff  <= '0;
            ms_cnt_ff  <= '0;
            ol_time_ff <= '0;
            ho_time_ff <= '0;
            grp_ff     <= 3'h0;
            behav_ff   <= TSM_MODE_ON;
        end else begin
            state_ff  <= nxt_state;
            grp_ff    <= nxt_grp;
            behav_ff  <= allow_node_operating_mode ? mode_ff : TSM_MODE_ON;
            nl_cnt_ff <= (lvl != 2'h0 || !(&dvld)) ? '0
                       : (nl_ok ? nl_cnt_ff : nl_cnt_ff + 1);
            ms_cnt_ff <= ms_tick ? '0 : ms_cnt_ff + 1;
            // A tick in the clearing cycle still counts
            ol_time_ff <= (clr_ol ? '0 : ol_time_ff)
                        + 32'(run && ms_tick && state_ff == TSM_ST_OVER);
            ho_time_ff <= (clr_ho ? '0 : ho_time_ff)
                        + 32'(run && ms_tick && state_ff == TSM_ST_HIGH);
        end
    end

    // Status outputs and events on any change
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stat_ff      <= '0;
            evt_valid_ff <= 1'b0;
            evt_stat_ff  <= '0;
            evt_test_ff  <= 1'b0;
        end else begin
            stat_ff      <= nxt_stat;
            evt_valid_ff <= ctrl_ff[CTRL_EVT_BIT]
                            && nxt_stat != stat_ff;
            evt_stat_ff  <= nxt_stat;
            evt_test_ff  <= behav_ff == TSM_MODE_TEST
                            || behav_ff == TSM_MODE_TESTBLK;
        end
    end

    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;
    assign shw_ready = shw_ready_ff;
    assign stat_out  = stat_ff;
    assign evt_valid = evt_valid_ff;
    assign evt_stat  = evt_stat_ff;
    assign evt_test  = evt_test_ff;

    // Checks
    a_noload_delay: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(state_ff == TSM_ST_NOLOAD) |-> $past(nl_cnt_ff) >= NOLOAD_CYCLES)
        else $error("no-load entered too early");
    a_inrush_both: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_ff == TSM_ST_NOLOAD && nxt_state == TSM_ST_INRUSH && run && !frc
         && behav_ff == $past(behav_ff))
        ##1 (run && !frc) |=> stat_ff.inrush_hv && stat_ff.inrush_lv)
        else $error("inrush outputs missing");
    a_one_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !frc |-> $onehot0({stat_ff.noload, stat_ff.normal, stat_ff.overload}))
        else $error("several load outputs");
    a_force_wins: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (frc && behav_ff != TSM_MODE_OFF) |=> stat_ff == frc2stat($past(force_ff)))
        else $error("forced status not shown");
    a_mode_locked: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !allow_node_operating_mode |=> $stable(mode_ff) && behav_ff == TSM_MODE_ON)
        else $error("mode changed while locked");
    a_ol_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (run && ms_tick && state_ff == TSM_ST_OVER && !clr_ol)
        |=> ol_time_ff == $past(ol_time_ff) + 1)
        else $error("overload time not counted");
    a_evt_change: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $past(ctrl_ff[CTRL_EVT_BIT]) && $changed(stat_ff) |-> evt_valid_ff
        && evt_stat_ff == stat_ff)
        else $error("status change without event");
    a_group_sel: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !ctrl_ff[CTRL_SG_BIT] |=> grp_ff == 3'h0)
        else $error("group used while group control off");
    a_apb_answer: assert property (@(posedge clk_sys) disable iff (sys_rst)
        psel && penable && !pready |=> pready)
        else $error("apb answer late");

endmodule : tsm_monitor

// File: pkg/tsm_pkg.sv
// Constants, register map and types of the transformer load-state monitor.
// Assumes a 10 MHz system clock and an APB register port with 32-bit data.
package tsm_pkg;

    // Timing
    localparam int unsigned CLK_HZ     = 10_000_000;
    localparam int unsigned NOLOAD_MS  = 10;
    localparam int unsigned MS_CYC     = CLK_HZ / 1000;
    localparam int unsigned NOLOAD_CYC = NOLOAD_MS * MS_CYC;

    // Load thresholds in tenths of nominal current
    localparam logic [7:0] TH_NOLOAD_X10 = 8'h02;  // 0.2 x In
    localparam logic [7:0] TH_NOM_X10    = 8'h0a;  // 1.0 x In
    localparam logic [7:0] TH_HEAVY_X10  = 8'h0d;  // 1.3 x In

    // Fixed-point factors (Q10) and scales of the derived quantities
    localparam logic [15:0] SQRT3_Q10  = 16'h06ee;   // 1.732
    localparam logic [15:0] TWO_PI_Q10 = 16'h1922;   // 6.283
    localparam logic [23:0] IN_SCALE   = 24'h9c4000; // 10000 * 1024
    localparam logic [15:0] ISC_SCALE  = 16'h2710;   // 10000
    localparam logic [15:0] LK_SCALE   = 16'h2800;   // 10 * 1024
    localparam int unsigned DIV_W      = 56;
    localparam int unsigned NUM_DIV    = 4;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_MODE    = 8'h04;
    localparam logic [7:0] OFF_BEHAV   = 8'h08;
    localparam logic [7:0] OFF_FORCE   = 8'h0c;
    localparam logic [7:0] OFF_STATUS  = 8'h10;
    localparam logic [7:0] OFF_OL_TIME = 8'h14;
    localparam logic [7:0] OFF_HO_TIME = 8'h18;
    localparam logic [7:0] OFF_TCLR    = 8'h1c;
    localparam logic [7:0] OFF_NP_BASE = 8'h20;  // five nameplate words
    localparam logic [7:0] OFF_IN_HV   = 8'h34;
    localparam logic [7:0] OFF_IN_LV   = 8'h38;
    localparam logic [7:0] OFF_ISC     = 8'h3c;
    localparam logic [7:0] OFF_LK      = 8'h40;

    // Control, time-clear and status register fields
    localparam int unsigned CTRL_SG_BIT   = 0;
    localparam int unsigned CTRL_EVT_BIT  = 1;
    localparam int unsigned CTRL_EDIT_LSB = 2;
    localparam int unsigned TCLR_OL_BIT   = 0;
    localparam int unsigned TCLR_HO_BIT   = 1;
    localparam int unsigned STAT_GRP_LSB  = 8;

    // Nameplate fields, units of one step
    localparam int unsigned NUM_GROUPS = 8;
    localparam int unsigned NUM_NP     = 5;
    localparam logic [2:0]  NP_P   = 3'h0;  // 0.1 MVA
    localparam logic [2:0]  NP_UHV = 3'h1;  // 0.1 kV
    localparam logic [2:0]  NP_ULV = 3'h2;  // 0.1 kV
    localparam logic [2:0]  NP_ZK  = 3'h3;  // 0.01 %
    localparam logic [2:0]  NP_F   = 3'h4;  // 1 Hz
    localparam logic [15:0] RST_P  = 16'h000a;
    localparam logic [15:0] RST_U  = 16'h044c;
    localparam logic [15:0] RST_ZK = 16'h012c;
    localparam logic [15:0] RST_F  = 16'h0032;
    localparam logic [15:0] MIN_PU = 16'h0001;
    localparam logic [15:0] MAX_PU = 16'h1388;
    localparam logic [15:0] MAX_ZK = 16'h09c4;
    localparam logic [15:0] MIN_F  = 16'h000a;
    localparam logic [15:0] MAX_F  = 16'h004b;

    typedef enum logic [2:0] {
        TSM_MODE_ON      = 3'h0,
        TSM_MODE_BLOCKED = 3'h1,
        TSM_MODE_TEST    = 3'h2,
        TSM_MODE_TESTBLK = 3'h3,
        TSM_MODE_OFF     = 3'h4
    } tsm_mode_t;

    typedef enum logic [2:0] {
        TSM_FRC_NONE    = 3'h0,  // forcing_inactive
        TSM_FRC_NOLOAD  = 3'h1,
        TSM_FRC_INR_HV  = 3'h2,
        TSM_FRC_INR_LV  = 3'h3,
        TSM_FRC_NORMAL  = 3'h4,
        TSM_FRC_OVER    = 3'h5,
        TSM_FRC_HIGH    = 3'h6
    } tsm_force_t;

    typedef enum logic [4:0] {
        TSM_ST_NOLOAD = 5'b00001,
        TSM_ST_NORMAL = 5'b00010,
        TSM_ST_OVER   = 5'b00100,
        TSM_ST_HIGH   = 5'b01000,
        TSM_ST_INRUSH = 5'b10000
    } tsm_state_t;

    typedef struct packed {
        logic noload;
        logic inrush_hv;
        logic inrush_lv;
        logic normal;
        logic overload;
        logic high_ol;
    } tsm_stat_t;

    // Shared-setting write from other transformer functions
    typedef struct packed {
        logic [2:0]  group;
        logic [2:0]  field;
        logic [15:0] data;
    } tsm_shw_t;

endpackage : tsm_pkg

// File: src/tsm_div.sv
// Free-running restoring divider; restarts itself after each result.
// Assumes operands stay meaningful for one full pass of W + 1 cycles.
`timescale 1ns/10ps
module tsm_div #(
    parameter int unsigned W = 56
) (
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] num,
    input  wire logic [W-1:0] den,
    output logic      [W-1:0] quo,
    output logic              ready
);
    localparam int unsigned CW = $clog2(W + 1);
    localparam logic [CW-1:0] CNT_LOAD = CW'(W);

    logic [W:0]    rem_ff;
    logic [W-1:0]  q_ff;
    logic [W-1:0]  d_ff;
    logic [CW-1:0] cnt_ff;
    logic [W-1:0]  quo_ff;
    logic          ready_ff;

    // One quotient bit per cycle; zero divisor yields all ones
    wire [W:0]   trial = {rem_ff[W-1:0], q_ff[W-1]};
    wire         ge    = trial >= {1'b0, d_ff};
    wire [W:0]   rem_n = ge ? trial - {1'b0, d_ff} : trial;
    wire [W-1:0] q_n   = {q_ff[W-2:0], ge};

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rem_ff   <= '0;
            q_ff     <= '0;
            d_ff     <= '0;
            cnt_ff   <= '0;
            quo_ff   <= '0;
            ready_ff <= 1'b0;
        end else if (cnt_ff == '0) begin
            rem_ff <= '0;
            q_ff   <= num;
            d_ff   <= den;
            cnt_ff <= CNT_LOAD;
        end else begin
            rem_ff <= rem_n;
            q_ff   <= q_n;
            cnt_ff <= cnt_ff - 1'b1;
            if (cnt_ff == 1) begin
                quo_ff   <= q_n;
                ready_ff <= 1'b1;
            end
        end
    end

    assign quo   = quo_ff;
    assign ready = ready_ff;

endmodule : tsm_div

// File: tb/tsm_cur_src.sv
// Behavioural current source in place of the measurement scaling stage.
// Assumes default nameplate: one nominal current is about 52 steps.
`timescale 1ns/10ps
module tsm_cur_src #(
    parameter int unsigned IN_STEPS = 52
) (
    input  wire logic        clk_sys,
    input  wire logic [7:0]  pu_x10,
    output logic      [19:0] cur_hv,
    output logic      [19:0] cur_lv
);
    // Same per-unit load on both windings, one cycle late
    always_ff @(posedge clk_sys) begin
        cur_hv <= 20'(pu_x10 * IN_STEPS / 10);
        cur_lv <= 20'(pu_x10 * IN_STEPS / 10);
    end
endmodule : tsm_cur_src

// File: tb/tb_transformer_load_state_monitor.sv
// Self-checking bench of the load-state monitor, APB master included.
// Assumes the monitor top tsm_monitor and the current source model.
`timescale 1ns/10ps
module tb_transformer_load_state_monitor
    import tsm_pkg::*;
;
    logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0, pu = 6;
    logic [31:0] pwdata = 0, prdata, rd_v;
    logic pready, pslverr, shw_ready, evt_valid, evt_test, err;
    logic allow_node_operating_mode = 1, stage_force_en = 1, shw_valid = 0;
    logic [2:0] sg = 0;
    logic [19:0] cur_hv, cur_lv;
    tsm_shw_t shw_req = '0;
    tsm_stat_t stat_out, evt_stat;
    logic [5:0] q[$];
    int n_fail = 0, samples_checked = 0;
    always #50 clk_sys = ~clk_sys;
    tsm_cur_src i_src (.clk_sys(clk_sys), .pu_x10(pu), .cur_hv(cur_hv),
        .cur_lv(cur_lv));
    tsm_monitor #(.NOLOAD_CYCLES(20), .MS_CYCLES(10)) i_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .meas_cur_hv(cur_hv), .meas_cur_lv(cur_lv),
        .allow_node_operating_mode(allow_node_operating_mode), .stage_force_en(stage_force_en),
        .settings_group_select(sg), .shw_valid(shw_valid),
        .shw_req(shw_req), .shw_ready(shw_ready), .stat_out(stat_out),
        .evt_valid(evt_valid), .evt_stat(evt_stat), .evt_test(evt_test));
    task automatic check(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s exp %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    // One APB transfer; holds the request until pready at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys) penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd_v = prdata; err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk_sys);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0);
        check("read data", rd_v, e);
    endtask : rd
    // New load level plus jitter; the expected event is noted first
    task automatic load(input logic [7:0] b, input logic [5:0] e);
        if (e != 0) q.push_back(e);
        pu <= b + 8'($urandom % 2);
        repeat (40) @(posedge clk_sys);
    endtask : load
    // Event watcher takes the oldest note for each pulse
    always @(posedge clk_sys) if (evt_valid === 1'b1) begin
        if (q.size() == 0) check("spurious event", 1, 0);
        else check("event", 32'(evt_stat), 32'(q.pop_front()));
    end
    initial begin
        #1_000_000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(30));
        repeat (2) @(posedge clk_sys);
        sys_rst <= 0;
        rd(OFF_MODE, 0);
        rd(OFF_NP_BASE, 32'(RST_P));
        rd(OFF_NP_BASE + 8'h10, 32'(RST_F));
        apb(0, 8'h44, 0);
        check("slave error", 32'(err), 1);
        repeat (80) @(posedge clk_sys);
        apb(1, OFF_CTRL, 32'h2);
        load(12, 6'b000010);
        for (int k = 1; k < 7; k++) begin
            q.push_back(6'b100000 >> (k - 1));
            apb(1, OFF_FORCE, 32'(k));
        end
        q.push_back(6'b000010);
        apb(1, OFF_FORCE, 0);
        // Light band shorter than the timer shows normal load
        q.push_back(6'b000100);
        pu <= 1;
        repeat (10) @(posedge clk_sys);
        load(6, 0);
        load(0, 6'b100000);
        apb(0, OFF_OL_TIME, 0);
        check("overload time", 32'(rd_v != 0), 1);
        apb(1, OFF_TCLR, 32'h1);
        rd(OFF_OL_TIME, 0);
        load(16, 6'b011000);
        load(6, 6'b000100);
        load(16, 6'b000001);
        apb(0, OFF_HO_TIME, 0);
        check("high time", 32'(rd_v != 0), 1);
        check("queue empty", q.size(), 0);
        // Events off, group control on, edit group 1 at 2.0 MVA
        apb(1, OFF_CTRL, 32'h5);
        apb(1, OFF_NP_BASE, 32'h14);
        sg <= 3'h1;
        repeat (120) @(posedge clk_sys);
        apb(0, OFF_STATUS, 0);
        check("active group", 32'(rd_v[10:8]), 1);
        apb(0, OFF_IN_HV, 0);
        // About 10.5 A, in 0.1 A steps
        check("nominal hv", 32'(rd_v >= 32'h68 && rd_v <= 32'h69), 1);
        apb(1, OFF_MODE, 32'h2);
        rd(OFF_BEHAV, 2);
        check("test flag", 32'(evt_test), 1);
        // Doubled nominal current turns the same load into normal
        check("status", 32'(stat_out), 32'h04);
        apb(1, OFF_MODE, 32'h4);
        repeat (2) @(posedge clk_sys);
        check("status off", 32'(stat_out), 0);
        apb(1, OFF_MODE, 32'h3);
        repeat (2) @(posedge clk_sys);
        check("test blocked", 32'({evt_test, stat_out}), 32'h40);
        allow_node_operating_mode <= 0;
        rd(OFF_BEHAV, 0);
        shw_req <= '{group: 3'h1, field: NP_F, data: 16'h003c};
        shw_valid <= 1;
        do @(posedge clk_sys); while (shw_ready !== 1'b1);
        shw_valid <= 0;
        rd(OFF_NP_BASE + 8'h10, 32'h3c);
        tally_and_finish();
    end
endmodule : tb_transformer_load_state_monitor
